/* File: common/bdmi_pkg.sv */
// Purpose: shared constants and types for the banked data memory
// Assumes: 8-bit data, 9-bit effective address {bank, offset}
// Notes:   offsets are bank 0 locations unless stated

package bdmi_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;

   localparam logic [7:0] OFS_INDIRECT_PORT_A  = 8'h00;
   localparam logic [7:0] OFS_POINTER_A        = 8'h01;
   localparam logic [7:0] OFS_INDIRECT_PORT_B  = 8'h02;
   localparam logic [7:0] OFS_POINTER_B        = 8'h03;
   localparam logic [7:0] OFS_BANK_SELECT      = 8'h04;
   localparam logic [7:0] OFS_WORKING_RESULT   = 8'h05;
   localparam logic [7:0] OFS_SFR_LAST         = 8'h3f;
   localparam logic [7:0] OFS_GPR_FIRST        = 8'h40;
   localparam logic [7:0] OFS_GPR_LAST         = 8'hbf;
   localparam logic [7:0] OFS_NV_CONTROL       = 8'h40;

   localparam int          GPR_DEPTH           = 128;
   localparam logic [7:0]  BANK_SELECT_RST     = 8'h00;
   localparam int          BANK_BIT_POS        = 0;
   localparam logic [7:0]  ZERO_BYTE           = 8'h00;

   // core-side access request
   typedef struct packed {
      logic       rdEn;
      logic       wrEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } bdmi_req_t;

   // bit-operation request for a single bit
   typedef struct packed {
      logic       en;
      logic       setBit;
      logic [2:0] bitSel;
      logic [7:0] addr;
   } bdmi_bitop_t;

   // access source selects how the address is formed
   typedef enum logic [1:0] {
      SRC_DIRECT = 2'b00,
      SRC_PORT_A = 2'b01,
      SRC_PORT_B = 2'b11
   } bdmi_src_t;
endpackage

/* File: rtl/bdmi_gpr_ram.sv */
// Purpose: 128 x 8 general purpose RAM with whole-byte writes only
// Assumes: synchronous write, asynchronous read
// Notes:   contents are volatile and not reset

`timescale 1ns/1ps
`default_nettype none

module bdmi_gpr_ram #(
   parameter int DEPTH = 128,
   parameter int WIDTH = 8
) (
   // clock
   input  wire logic                     core_clk,
   // byte write
   input  wire logic                     wrEn,
   input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
   input  wire logic [WIDTH-1:0]         wrData,
   // read
   input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
   output logic      [WIDTH-1:0]         rdData
);
   import bdmi_pkg::*;

   if (DEPTH < 2 || WIDTH != DATA_W) begin
      $error("bdmi_gpr_ram: unsupported depth or width");
   end

   // (RQ1) byte-wide volatile store
   logic [WIDTH-1:0] mem [DEPTH];

   assign rdData = mem[rdAddr];

   always_ff @(posedge core_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end
endmodule

`default_nettype wire

/* File: rtl/bdmi_data_memory.sv */
// What this block does
// (RQ1) every location is eight bits, volatile, first address zero
// (RQ2) special area 00H-3FH in bank 0; bank 1 holds control at 40H
// (RQ3) bank 0 40H-BFH is 128 bytes of read/write RAM
// (RQ4) unused special locations read back zero
// (RQ5) read-only special registers ignore writes
// (RQ6) indirect ports act on the location named by their pointer
// (RQ7) port a reaches bank 0 only; port b follows bank select
// (RQ8) pointer at an indirect port: read zero, write ignored
// (RQ9) both pointers are real read/write registers
// (RQ10) direct accesses always go to bank 0
// (RQ11) bank select bit 0 picks the bank, bits 7-1 read zero
// (RQ12) reset clears bank select unless watchdog reset in low power
// (RQ13) bit operations change one RAM bit, others kept
// (RQ14) no memory-to-memory move; data passes the accumulator
// (RQ15) the accumulator takes the arithmetic unit results
// (RQ16) port b address is {bank bit, pointer}; unmapped bank 1 reads 0
//
// Purpose: data memory decode for the core, with indirect access
// Assumes: one access per cycle; reads are combinational
// Notes:   peripheral registers live outside; their locations are
//          forwarded on the sfr* ports

`timescale 1ns/1ps
`default_nettype none

module bdmi_data_memory #(
   parameter int GPR_WORDS = bdmi_pkg::GPR_DEPTH
) (
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   // reset cause: watchdog time-out taken in sleep or idle
   input  wire logic                wdtLowPowerRst,
   // core access
   input  wire bdmi_pkg::bdmi_req_t coreReq,
   output logic [7:0]               rdData,
   // bit operation on data memory
   input  wire bdmi_pkg::bdmi_bitop_t bitOp,
   // accumulator load from the arithmetic unit
   input  wire logic                aluLoad,
   input  wire logic [7:0]          aluResult,
   output logic [7:0]               accValue,
   // external special registers (bank 0, 06H-3FH) and control at 40H
   output logic                     sfrWrEn,
   output logic                     sfrRdEn,
   output logic [7:0]               sfrAddr,
   output logic [7:0]               sfrWrData,
   input  wire logic [7:0]          sfrRdData,
   input  wire logic                sfrPresent,
   input  wire logic                sfrReadOnly,
   output logic                     nvCtrlWrEn,
   output logic                     nvCtrlRdEn,
   input  wire logic [7:0]          nvCtrlRdData,
   // state
   output logic                     bankSel
);
   import bdmi_pkg::*;

   // elaboration check: the decode below is fixed to 128 bytes
   if (GPR_WORDS != GPR_DEPTH) begin
      $error("bdmi_data_memory: GPR_WORDS must be 128");
   end

   localparam int GA_W = $clog2(GPR_WORDS);

   logic [7:0] pointerA_reg;
   logic [7:0] pointerB_reg;
   logic       bankSel_reg;
   logic       bankSelHeld_reg;
   logic [7:0] acc_reg;

   function automatic logic isPort(input logic [7:0] a);
      return (a == OFS_INDIRECT_PORT_A) || (a == OFS_INDIRECT_PORT_B);
   endfunction

   function automatic logic isGpr(input logic [7:0] a);
      return (a >= OFS_GPR_FIRST) && (a <= OFS_GPR_LAST);
   endfunction

   // (RQ6) resolve source
   // a port access never touches a register; it is redirected
   wire        dirA   = (coreReq.addr == OFS_INDIRECT_PORT_A);
   wire        dirB   = (coreReq.addr == OFS_INDIRECT_PORT_B);
   wire bdmi_src_t src = dirA ? SRC_PORT_A : (dirB ? SRC_PORT_B : SRC_DIRECT);

   // (RQ7) bank per port
   // (RQ10) direct is bank 0
   // (RQ16) port b address
   wire [7:0] effAddr = (src == SRC_PORT_A) ? pointerA_reg :
                        (src == SRC_PORT_B) ? pointerB_reg : coreReq.addr;
   wire       effBank = (src == SRC_PORT_B) ? bankSel_reg : 1'b0;

   // (RQ8) pointer aimed at a port
   wire nullAcc = (src != SRC_DIRECT) && isPort(effAddr);

   // (RQ2) bank decode
   wire b0      = !effBank && !nullAcc;
   wire hitPtrA = b0 && (effAddr == OFS_POINTER_A);
   wire hitPtrB = b0 && (effAddr == OFS_POINTER_B);
   wire hitBank = b0 && (effAddr == OFS_BANK_SELECT);
   wire hitAcc  = b0 && (effAddr == OFS_WORKING_RESULT);
   wire hitGpr  = b0 && isGpr(effAddr);
   wire hitSfr  = b0 && (effAddr > OFS_WORKING_RESULT) &&
                  (effAddr <= OFS_SFR_LAST);
   wire hitNv   = effBank && !nullAcc && (effAddr == OFS_NV_CONTROL);

   wire wr = coreReq.wrEn;
   wire rd = coreReq.rdEn;

   // (RQ13) read-modify-write of one bit, bank 0 only
   wire        bitHitGpr = bitOp.en && isGpr(bitOp.addr);
   wire [GA_W-1:0] bitIdx = GA_W'(bitOp.addr - OFS_GPR_FIRST);
   wire [GA_W-1:0] accIdx = GA_W'(effAddr - OFS_GPR_FIRST);
   wire [GA_W-1:0] ramRdIdx = bitHitGpr ? bitIdx : accIdx;
   wire [7:0]  ramRd;
   wire [7:0]  bitMask = 8'h01 << bitOp.bitSel;
   wire [7:0]  bitNew  = bitOp.setBit ? (ramRd | bitMask)
                                      : (ramRd & ~bitMask);

   // (RQ3) general purpose RAM
   wire        ramWe   = bitHitGpr || (wr && hitGpr);
   wire [7:0]  ramWd   = bitHitGpr ? bitNew : coreReq.wrData;

   bdmi_gpr_ram #(
      .DEPTH (GPR_WORDS),
      .WIDTH (DATA_W)
   ) u_ram (
      .core_clk (core_clk),
      .wrEn     (ramWe),
      .wrAddr   (ramRdIdx),
      .wrData   (ramWd),
      .rdAddr   (ramRdIdx),
      .rdData   (ramRd)
   );

   // (RQ5) read-only sfr writes dropped
   assign sfrAddr    = effAddr;
   assign sfrWrData  = coreReq.wrData;
   assign sfrWrEn    = wr && hitSfr && sfrPresent && !sfrReadOnly;
   assign sfrRdEn    = rd && hitSfr;
   assign nvCtrlWrEn = wr && hitNv;
   assign nvCtrlRdEn = rd && hitNv;

   // (RQ11) bit 0 only, upper bits zero
   wire [7:0] bankView = {7'h00, bankSel_reg};

   // (RQ4) unused reads zero
   // (RQ16) unmapped bank 1 reads zero
   // (RQ14) single source per read; no path from a read to a write
   assign rdData = !rd      ? ZERO_BYTE :
                   hitPtrA  ? pointerA_reg :
                   hitPtrB  ? pointerB_reg :
                   hitBank  ? bankView :
                   hitAcc   ? acc_reg :
                   hitGpr   ? ramRd :
                   (hitSfr && sfrPresent) ? sfrRdData :
                   hitNv    ? nvCtrlRdData : ZERO_BYTE;

   // (RQ9) pointer registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pointerA_reg <= ZERO_BYTE;
         pointerB_reg <= ZERO_BYTE;
      end else begin
         if (wr && hitPtrA) pointerA_reg <= coreReq.wrData;
         if (wr && hitPtrB) pointerB_reg <= coreReq.wrData;
      end
   end

   // (RQ15) accumulator load, alu result wins over a store
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg <= ZERO_BYTE;
      end else if (aluLoad) begin
         acc_reg <= aluResult;
      end else if (wr && hitAcc) begin
         acc_reg <= coreReq.wrData;
      end
   end

   // bank bit backup: frozen while reset is low, otherwise it would
   // copy the forced zero and a watchdog restore would lose the bank
   always_ff @(posedge core_clk) begin
      if (rst_n) begin
         bankSelHeld_reg <= bankSel_reg;
      end
   end

   // (RQ12) bank select after reset
   // async reset forces zero; on release the held value is restored if
   // the reset was a watchdog time-out in low power
   logic rstSeen_reg;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bankSel_reg <= BANK_SELECT_RST[BANK_BIT_POS];
         rstSeen_reg <= 1'b1;
      end else begin
         rstSeen_reg <= 1'b0;
         if (rstSeen_reg && wdtLowPowerRst) begin
            bankSel_reg <= bankSelHeld_reg;
         end else if (wr && hitBank) begin
            bankSel_reg <= coreReq.wrData[BANK_BIT_POS];
         end
      end
   end

   assign accValue = acc_reg;
   assign bankSel  = bankSel_reg;

   // assertions: same-cycle decode and one-cycle register effects
   direct_bank0_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (src == SRC_DIRECT) |-> !effBank) // RQ10
      else $error("direct access left bank 0");

   port_a_bank0_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (src == SRC_PORT_A) |-> !effBank && !hitNv) // RQ7
      else $error("port a reached bank 1");

   null_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rd && nullAcc) |-> rdData == ZERO_BYTE) // RQ8
      else $error("port self read not zero");

   null_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (wr && nullAcc && !aluLoad && !bitOp.en) |=>
      $stable(pointerA_reg) && $stable(pointerB_reg) &&
      $stable(acc_reg) && $stable(bankSel_reg)) // RQ8
      else $error("port self write changed state");

   bank_view_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rd && hitBank) |-> rdData[7:1] == 7'h00) // RQ11
      else $error("bank select upper bits not zero");

   ptr_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (wr && hitPtrB) |=> pointerB_reg == $past(coreReq.wrData)) // RQ9
      else $error("pointer b not written");

   bank_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (wr && hitBank && !rstSeen_reg) |=>
      bankSel_reg == $past(coreReq.wrData[0])) // RQ11
      else $error("bank select not written");

   ro_guard_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      sfrReadOnly |-> !sfrWrEn) // RQ5
      else $error("write reached a read-only register");

   acc_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      aluLoad |=> accValue == $past(aluResult)) // RQ15
      else $error("accumulator missed alu result");

   unused_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rd && hitSfr && !sfrPresent) |-> rdData == ZERO_BYTE) // RQ4
      else $error("unused location read not zero");

   bank1_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rd && effBank && !hitNv) |-> rdData == ZERO_BYTE) // RQ16
      else $error("unmapped bank 1 read not zero");
endmodule

`default_nettype wire

/* File: test/bdmi_sfr_model.sv */
// Purpose: peripheral registers beside the data memory
// Assumes: 06H-2FH implemented, 08H read-only, 30H-3FH unused
// Notes:   control register write data comes on sfrWrData
`timescale 1ns/1ps
`default_nettype none
module bdmi_sfr_model (
   // clock
   input  wire logic       core_clk,
   // memory side
   input  wire logic       sfrWrEn,
   input  wire logic [7:0] sfrAddr,
   input  wire logic [7:0] sfrWrData,
   input  wire logic       nvCtrlWrEn,
   output logic      [7:0] sfrRdData,
   output logic            sfrPresent,
   output logic            sfrReadOnly,
   output logic      [7:0] nvCtrlRdData
);
   logic [7:0] regsReg [64];
   logic [7:0] nvReg = 8'h00;
   assign sfrPresent   = sfrAddr < 8'h30;
   assign sfrReadOnly  = sfrAddr == 8'h08;
   assign sfrRdData    = sfrReadOnly ? 8'h5a : regsReg[sfrAddr[5:0]];
   assign nvCtrlRdData = nvReg;
   always @(posedge core_clk) begin
      if (sfrWrEn)
         regsReg[sfrAddr[5:0]] <= sfrWrData;
      if (nvCtrlWrEn)
         nvReg <= sfrWrData;
   end
endmodule
`default_nettype wire

/* File: test/test_banked_data_memory_indirect.sv */
// Purpose: self-checking bench for the banked data memory
// Assumes: inputs change at the falling edge
// Notes:   a bench copy of RAM gives the expected bytes
`timescale 1ns/1ps
`default_nettype none
module test_banked_data_memory_indirect;
   import bdmi_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wdtLowPowerRst = 1'b0;
   bdmi_req_t   coreReq = '0;
   bdmi_bitop_t bitOp = '0;
   logic        aluLoad = 1'b0;
   logic [7:0]  aluResult = 8'h00;
   logic [7:0]  rdData, accValue, sfrAddr, sfrWrData, sfrRdData;
   logic [7:0]  nvCtrlRdData;
   logic        sfrWrEn, sfrRdEn, sfrPresent, sfrReadOnly;
   logic        nvCtrlWrEn, nvCtrlRdEn, bankSel, lastWr;
   logic [1:0]  rdStb;
   int          failCount = 0;
   int          checksDone = 0;
   int          cycles = 0;
   logic [16:0] seed = 17'h16ffc;
   logic [7:0]  mem [128];
   always #2 core_clk = ~core_clk;
   bdmi_data_memory DUT (.core_clk, .rst_n, .wdtLowPowerRst, .coreReq,
      .rdData, .bitOp, .aluLoad, .aluResult, .accValue, .sfrWrEn,
      .sfrRdEn, .sfrAddr, .sfrWrData, .sfrRdData, .sfrPresent,
      .sfrReadOnly, .nvCtrlWrEn, .nvCtrlRdEn, .nvCtrlRdData, .bankSel);
   bdmi_sfr_model partner (.core_clk, .sfrWrEn, .sfrAddr, .sfrWrData,
      .nvCtrlWrEn, .sfrRdData, .sfrPresent, .sfrReadOnly, .nvCtrlRdData);
   function automatic logic [16:0] nxt(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   function automatic logic [7:0] bitset(input logic [7:0] v,
                                         input int b, input logic s);
      v[b] = s;
      return v;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checksDone++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(negedge core_clk);
      coreReq = '{1'b0, 1'b1, ad, dt};
      #1 lastWr = sfrWrEn;
      @(negedge core_clk);
      coreReq = '0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
      @(negedge core_clk);
      coreReq = '{1'b1, 1'b0, ad, 8'h00};
      #1 chk(rdData, exp);
      rdStb = {sfrRdEn, nvCtrlRdEn};
      @(negedge core_clk);
      coreReq = '0;
   endtask
   task automatic bop(input logic [7:0] ad, input int b, input logic s);
      @(negedge core_clk);
      bitOp = '{1'b1, s, b[2:0], ad};
      @(negedge core_clk);
      bitOp = '0;
   endtask
   task automatic do_reset(input logic wdt);
      @(negedge core_clk);
      rst_n = 1'b0;
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      wdtLowPowerRst = wdt;
      @(negedge core_clk);
      wdtLowPowerRst = 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failCount++;
         tally_and_finish;
      end
   end
   initial begin
      do_reset(1'b0);
      chk({7'h0, bankSel}, 8'h00);
      rd(OFS_BANK_SELECT, 8'h00);
      for (int i = 0; i < 128; i++) begin
         seed = nxt(seed);
         mem[i] = seed[7:0];
         wr(8'h40 + i[7:0], seed[7:0]);
      end
      for (int i = 0; i < 128; i++) begin
         rd(8'h40 + i[7:0], mem[i]);
      end
      rd(8'h3f, 8'h00);
      wr(8'h08, 8'h11);
      chk({7'h0, lastWr}, 8'h00);
      rd(8'h08, 8'h5a);
      wr(8'h10, 8'h3c);
      rd(8'h10, 8'h3c);
      chk({6'h00, rdStb}, 8'h02);
      wr(OFS_POINTER_A, 8'hbf);
      rd(OFS_POINTER_A, 8'hbf);
      wr(OFS_INDIRECT_PORT_A, 8'ha5);
      mem[8'h7f] = 8'ha5;
      rd(8'hbf, 8'ha5);
      wr(OFS_POINTER_A, 8'h00);
      wr(OFS_INDIRECT_PORT_A, 8'h77);
      rd(OFS_INDIRECT_PORT_A, 8'h00);
      rd(OFS_POINTER_A, 8'h00);
      wr(OFS_BANK_SELECT, 8'hff);
      rd(OFS_BANK_SELECT, 8'h01);
      wr(OFS_POINTER_B, 8'h40);
      wr(OFS_INDIRECT_PORT_B, 8'h6b);
      rd(OFS_INDIRECT_PORT_B, 8'h6b);
      chk({6'h00, rdStb}, 8'h01);
      rd(8'h40, mem[0]);
      wr(OFS_POINTER_A, 8'h41);
      rd(OFS_INDIRECT_PORT_A, mem[1]);
      wr(OFS_POINTER_B, 8'h41);
      wr(OFS_INDIRECT_PORT_B, 8'h99);
      rd(OFS_INDIRECT_PORT_B, 8'h00);
      rd(8'h41, mem[1]);
      do_reset(1'b1);
      chk({7'h0, bankSel}, 8'h01);
      do_reset(1'b0);
      chk({7'h0, bankSel}, 8'h00);
      for (int b = 0; b < 8; b++) begin
         seed = nxt(seed);
         bop(8'h50, b, seed[0]);
         mem[8'h10] = bitset(mem[8'h10], b, seed[0]);
         rd(8'h50, mem[8'h10]);
      end
      @(negedge core_clk);
      aluLoad = 1'b1;
      aluResult = 8'hc3;
      coreReq = '{1'b0, 1'b1, OFS_WORKING_RESULT, 8'h3c};
      @(negedge core_clk);
      aluLoad = 1'b0;
      coreReq = '0;
      chk(accValue, 8'hc3);
      wr(OFS_WORKING_RESULT, 8'h5e);
      chk(accValue, 8'h5e);
      tally_and_finish;
   end
endmodule
`default_nettype wire
